// [pkg/ccp_pkg.sv]
/*
 * Constants for the two-unit capture/compare/PWM register block.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
// How it works
// - control bit 7 enables the unit; zero disables it.
// - control bit 5 reads back the output level; writes ignored.
// - control bit 4 picks left or right duty alignment in PWM only.
// - mode 1111 is PWM, 0000 resets the unit, 1100-1110 reserved.
// - mode 1000 sets output on match, 1001 clears it.
// - modes 1010/1011 pulse output on match; 1011 clears wide timer.
// - modes 0010/0001 toggle output on match; 0001 clears wide timer.
// - capture on any edge 0011, falling 0100, rising 0101.
// - capture every 4th rising edge 0110, every 16th 0111.
// - every mode event sets the unit flag and converter trigger if chosen.
// - capture source select picks pin, comparators, pin change, logic cells 0-3.
// - capture copies wide timer low and high bytes into data bytes.
// - compare matches data bytes against wide timer bytes.
// - right aligned: low byte is bits 7:0, high bits 1:0 top.
// - left aligned: high byte is top eight, low bits 7:6 bottom.
// - unit timer choice 01 picks period timer a, 10 period timer b.
// - standalone PWM timer choices in bits 7-6 and 5-4, same codes.
// - after period match: restart, set output unless zero duty, latch duty.
// - output goes low when 10-bit time base equals buffered duty.
package ccp_pkg;
   // ------------------------------------------------------------
   // register map, 4 registers per unit then shared route
   // ------------------------------------------------------------
   localparam logic [7:0] CCP_UNIT_STRIDE   = 8'h10;
   localparam logic [7:0] CCP_OFF_CONTROL   = 8'h00;
   localparam logic [7:0] CCP_OFF_CAPSEL    = 8'h04;
   localparam logic [7:0] CCP_OFF_DATA_LOW  = 8'h08;
   localparam logic [7:0] CCP_OFF_DATA_HIGH = 8'h0c;
   localparam logic [7:0] CCP_OFF_ROUTE     = 8'h20;
   localparam logic [7:0] CCP_OFF_FLAGS     = 8'h24;
   // ------------------------------------------------------------
   // fields and resets
   // ------------------------------------------------------------
   localparam int         CCP_BIT_ENABLE  = 7;
   localparam int         CCP_BIT_OUT     = 5;
   localparam int         CCP_BIT_ALIGN   = 4;
   localparam logic [7:0] CCP_CONTROL_RST = 8'h00;
   localparam logic [7:0] CCP_CAPSEL_RST  = 8'h00;
   localparam logic [7:0] CCP_ROUTE_RST   = 8'h55;
   localparam logic [7:0] CCP_CONTROL_WMASK = 8'h9f;
   localparam logic [7:0] CCP_CAPSEL_WMASK  = 8'h07;
   // ------------------------------------------------------------
   // modes and timer codes
   // ------------------------------------------------------------
   localparam logic [3:0] CCP_M_OFF      = 4'h0;
   localparam logic [3:0] CCP_M_TOG_CLR  = 4'h1;
   localparam logic [3:0] CCP_M_TOG      = 4'h2;
   localparam logic [3:0] CCP_M_CAP_ANY  = 4'h3;
   localparam logic [3:0] CCP_M_CAP_FALL = 4'h4;
   localparam logic [3:0] CCP_M_CAP_RISE = 4'h5;
   localparam logic [3:0] CCP_M_CAP_4    = 4'h6;
   localparam logic [3:0] CCP_M_CAP_16   = 4'h7;
   localparam logic [3:0] CCP_M_SET      = 4'h8;
   localparam logic [3:0] CCP_M_CLR      = 4'h9;
   localparam logic [3:0] CCP_M_PULSE    = 4'ha;
   localparam logic [3:0] CCP_M_PULSE_CL = 4'hb;
   localparam logic [3:0] CCP_M_PWM      = 4'hf;
   localparam logic [1:0] CCP_T_A        = 2'h1;
   localparam logic [1:0] CCP_T_B        = 2'h2;
endpackage

// [rtl/ccp_regs.sv]
/*
 * Two capture/compare/PWM units, their registers and two standalone PWM
 * timer routes, behind a classic Wishbone slave.
 * Assumes timers, their 10-bit time bases and trigger sources are
 * synchronous to clk_i; wide timer clear is a request to the timer.
 */
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ccp_regs
   import ccp_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // timers
   input  wire logic [15:0] wide_timer_i,
   input  wire logic [9:0]  period_base_a_i,
   input  wire logic [9:0]  period_base_b_i,
   input  wire logic        period_wrap_a_i,
   input  wire logic        period_wrap_b_i,
   // capture sources, unused seconds tick and converter unit select
   input  wire logic [1:0]  remapped_input_pin_i,
   input  wire logic        comparator_one_result_i,
   input  wire logic        comparator_two_result_i,
   input  wire logic        pin_change_event_i,
   input  wire logic [3:0]  logic_cell_result_i,
   input  wire logic        calendar_seconds_tick_i,
   input  wire logic [1:0]  converter_source_i,
   // unit outputs
   output logic      [1:0]  unit_out_o,
   output logic      [1:0]  unit_interrupt_flag_o,
   output logic             wide_timer_clear_o,
   output logic             converter_trigger_o,
   output logic      [1:0]  pwm_a_timer_o,
   output logic      [1:0]  pwm_b_timer_o
);
   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   logic       req;
   logic       wr;
   logic [7:0] wbyte;
   logic [7:0] timer_route_select;
   logic [1:0] flag_clr;

   assign req   = cyc_i & stb_i & ~ack_o;
   assign wr    = req & we_i & sel_i[0];
   assign wbyte = dat_i[7:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_route_select <= CCP_ROUTE_RST;
      end else if (wr && adr_i == CCP_OFF_ROUTE) begin
         timer_route_select <= wbyte;
      end
   end

   // flag bits cleared by writing one
   assign flag_clr = (wr && adr_i == CCP_OFF_FLAGS) ? wbyte[1:0] : 2'h0;

   // ------------------------------------------------------------
   // standalone PWM routes; reserved codes shown as zero
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_a_timer_o <= 2'h0;
         pwm_b_timer_o <= 2'h0;
      end else begin
         pwm_a_timer_o <= (timer_route_select[5:4] == CCP_T_A ||
                           timer_route_select[5:4] == CCP_T_B) ?
                          timer_route_select[5:4] : 2'h0;
         pwm_b_timer_o <= (timer_route_select[7:6] == CCP_T_A ||
                           timer_route_select[7:6] == CCP_T_B) ?
                          timer_route_select[7:6] : 2'h0;
      end
   end

   // ------------------------------------------------------------
   // per unit logic
   // ------------------------------------------------------------
   logic [7:0] unit_control [2];
   logic [7:0] capsel       [2];
   logic [7:0] data_low     [2];
   logic [7:0] data_high    [2];
   logic [1:0] clr_req;
   logic [1:0] event_hit;

   genvar u;
   generate
      for (u = 0; u < 2; u++) begin : g_unit
         localparam logic [7:0] BASE = CCP_UNIT_STRIDE * 8'(u);
         logic [3:0] mode;
         logic       en;
         logic       align;
         logic [1:0] tsel;
         logic       tsel_ok;
         logic       src;
         logic       src_q;
         logic       rise;
         logic       fall;
         logic [3:0] prescale;
         logic       cap_hit;
         logic       match;
         logic       match_q;
         logic       cmp_hit;
         logic       cmp_mode;
         logic       pulse_on;
         logic [9:0] duty;
         logic [9:0] duty_buf;
         logic [9:0] base;
         logic       wrap;
         logic       active;

         assign mode  = unit_control[u][3:0];
         assign en    = unit_control[u][CCP_BIT_ENABLE];
         assign align = unit_control[u][CCP_BIT_ALIGN];
         assign tsel  = (u == 0) ? timer_route_select[1:0] : timer_route_select[3:2];
         assign tsel_ok = (tsel == CCP_T_A) || (tsel == CCP_T_B);
         assign active  = en && tsel_ok && mode != CCP_M_OFF;

         // ------------------------------------------------------
         // capture source mux
         // ------------------------------------------------------
         always_comb begin
            case (capsel[u][2:0])
               3'h0: src = remapped_input_pin_i[u];
               3'h1: src = comparator_one_result_i;
               3'h2: src = comparator_two_result_i;
               3'h3: src = pin_change_event_i;
               3'h4: src = logic_cell_result_i[0];
               3'h5: src = logic_cell_result_i[1];
               3'h6: src = logic_cell_result_i[2];
               default: src = logic_cell_result_i[3];
            endcase
         end

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               src_q <= 1'b0;
            end else begin
               src_q <= src;
            end
         end
         assign rise = src & ~src_q;
         assign fall = ~src & src_q;

         // ------------------------------------------------------
         // capture edge selection
         // ------------------------------------------------------
         always_comb begin
            case (mode)
               CCP_M_CAP_ANY:  cap_hit = rise | fall;
               CCP_M_CAP_FALL: cap_hit = fall;
               CCP_M_CAP_RISE: cap_hit = rise;
               CCP_M_CAP_4:    cap_hit = rise && prescale[1:0] == 2'h3;
               CCP_M_CAP_16:   cap_hit = rise && prescale == 4'hf;
               default:        cap_hit = 1'b0;
            endcase
            cap_hit = cap_hit & active;
         end

         always_ff @(posedge clk_i) begin
            if (rst_i || !active) begin
               prescale <= 4'h0;
            end else if (rise) begin
               prescale <= prescale + 4'h1;
            end
         end

         // ------------------------------------------------------
         // compare on both bytes, one event per match entry
         // ------------------------------------------------------
         assign match   = (wide_timer_i[7:0] == data_low[u]) &&
                          (wide_timer_i[15:8] == data_high[u]);

         // modes that act on a compare match
         always_comb begin
            case (mode)
               CCP_M_TOG_CLR,
               CCP_M_TOG,
               CCP_M_SET,
               CCP_M_CLR,
               CCP_M_PULSE,
               CCP_M_PULSE_CL: cmp_mode = 1'b1;
               default:        cmp_mode = 1'b0;
            endcase
         end

         assign cmp_hit = active && match && !match_q && cmp_mode;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               match_q <= 1'b0;
            end else begin
               match_q <= match;
            end
         end

         // ------------------------------------------------------
         // pwm time base and duty format
         // ------------------------------------------------------
         assign base = (tsel == CCP_T_B) ? period_base_b_i : period_base_a_i;
         assign wrap = (tsel == CCP_T_B) ? period_wrap_b_i : period_wrap_a_i;
         assign duty = align ? {data_high[u], data_low[u][7:6]}
                             : {data_high[u][1:0], data_low[u]};

         // ------------------------------------------------------
         // registers; capture loads the data bytes
         // ------------------------------------------------------
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               unit_control[u] <= CCP_CONTROL_RST;
               capsel[u]       <= CCP_CAPSEL_RST;
               data_low[u]     <= 8'h00;
               data_high[u]    <= 8'h00;
            end else begin
               if (wr && adr_i == BASE + CCP_OFF_CONTROL) begin
                  unit_control[u] <= wbyte & CCP_CONTROL_WMASK;
               end
               if (wr && adr_i == BASE + CCP_OFF_CAPSEL) begin
                  capsel[u] <= wbyte & CCP_CAPSEL_WMASK;
               end
               if (cap_hit) begin
                  data_low[u]  <= wide_timer_i[7:0];
                  data_high[u] <= wide_timer_i[15:8];
               end else begin
                  if (wr && adr_i == BASE + CCP_OFF_DATA_LOW) begin
                     data_low[u] <= wbyte;
                  end
                  if (wr && adr_i == BASE + CCP_OFF_DATA_HIGH) begin
                     data_high[u] <= wbyte;
                  end
               end
            end
         end

         // ------------------------------------------------------
         // output level
         // ------------------------------------------------------
         always_ff @(posedge clk_i) begin
            if (rst_i || mode == CCP_M_OFF || !en) begin
               unit_out_o[u] <= 1'b0;
               pulse_on      <= 1'b0;
               duty_buf      <= 10'h000;
            end else if (tsel_ok) begin
               pulse_on <= 1'b0;
               if (mode == CCP_M_PWM) begin
                  if (wrap) begin
                     duty_buf      <= duty;
                     unit_out_o[u] <= (duty != 10'h000);
                  end else if (base == duty_buf) begin
                     unit_out_o[u] <= 1'b0;
                  end
               end else if (pulse_on) begin
                  unit_out_o[u] <= 1'b0;
               end else if (cmp_hit) begin
                  case (mode)
                     CCP_M_SET:                 unit_out_o[u] <= 1'b1;
                     CCP_M_CLR:                 unit_out_o[u] <= 1'b0;
                     CCP_M_PULSE, CCP_M_PULSE_CL: begin
                        unit_out_o[u] <= 1'b1;
                        pulse_on      <= 1'b1;
                     end
                     CCP_M_TOG, CCP_M_TOG_CLR: unit_out_o[u] <= ~unit_out_o[u];
                     default:                   unit_out_o[u] <= unit_out_o[u];
                  endcase
               end
            end
         end

         assign clr_req[u]   = cmp_hit && (mode == CCP_M_TOG_CLR || mode == CCP_M_PULSE_CL);
         assign event_hit[u] = cap_hit | cmp_hit |
                               (active && mode == CCP_M_PWM && wrap);

         // ------------------------------------------------------
         // sticky flag, set wins over clear
         // ------------------------------------------------------
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               unit_interrupt_flag_o[u] <= 1'b0;
            end else if (event_hit[u]) begin
               unit_interrupt_flag_o[u] <= 1'b1;
            end else if (flag_clr[u]) begin
               unit_interrupt_flag_o[u] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // timer clear request and converter trigger
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wide_timer_clear_o  <= 1'b0;
         converter_trigger_o <= 1'b0;
      end else begin
         wide_timer_clear_o  <= |clr_req;
         converter_trigger_o <= |(event_hit & converter_source_i);
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [7:0] rbyte;
   always_comb begin
      rbyte = 8'h00;
      for (int i = 0; i < 2; i++) begin
         if (adr_i == CCP_UNIT_STRIDE * 8'(i) + CCP_OFF_CONTROL) begin
            rbyte = unit_control[i];
            rbyte[CCP_BIT_OUT] = unit_out_o[i];
         end
         if (adr_i == CCP_UNIT_STRIDE * 8'(i) + CCP_OFF_CAPSEL) begin
            rbyte = capsel[i];
         end
         if (adr_i == CCP_UNIT_STRIDE * 8'(i) + CCP_OFF_DATA_LOW) begin
            rbyte = data_low[i];
         end
         if (adr_i == CCP_UNIT_STRIDE * 8'(i) + CCP_OFF_DATA_HIGH) begin
            rbyte = data_high[i];
         end
      end
      if (adr_i == CCP_OFF_ROUTE) begin
         rbyte = timer_route_select;
      end
      if (adr_i == CCP_OFF_FLAGS) begin
         rbyte = {6'h00, unit_interrupt_flag_o};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req) begin
         dat_o <= {24'h00_0000, rbyte};
      end
   end
endmodule

// [bench/ccp_regs_assertions.sv]
/*
 * Checker for ccp_regs: bus answer, control readback, route codes,
 * compare side effects. Bound to every ccp_regs instance.
 */
`timescale 1ns/1ps
module ccp_regs_assertions
   import ccp_pkg::*;
(
   // clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // unit side
   input wire logic [1:0]  converter_source_i,
   input wire logic [1:0]  unit_out_o,
   input wire logic [1:0]  unit_interrupt_flag_o,
   input wire logic        wide_timer_clear_o,
   input wire logic        converter_trigger_o,
   input wire logic [1:0]  pwm_a_timer_o,
   input wire logic [1:0]  pwm_b_timer_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   logic wr;
   logic rd_ctl;
   logic rd_cap;
   assign take   = cyc_i & stb_i & ~ack_o;
   assign wr     = take & we_i & sel_i[0];
   assign rd_ctl = take & ~we_i & (adr_i == CCP_OFF_CONTROL);
   assign rd_cap = take & ~we_i & (adr_i == CCP_OFF_CAPSEL);
   // reserved route codes show on the standalone timer outputs as no timer
   function automatic logic [1:0] route(input logic [1:0] c);
      return (c == CCP_T_A || c == CCP_T_B) ? c : 2'h0;
   endfunction
   chk_ack_answer: assert property (take |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle after request");
   chk_ack_cause: assert property (ack_o |-> $past(take))
      else $error("ack without request");
   chk_out_readback: assert property (
      $past(rd_ctl) |-> dat_o[6] == 1'b0 && dat_o[5] == $past(unit_out_o[0]))
      else $error("control readback of output level wrong");
   chk_capsel_mask: assert property (
      $past(rd_cap) |-> dat_o[31:3] == 29'h0)
      else $error("capture select upper bits not zero");
   chk_off_quiet: assert property (
      wr && adr_i == CCP_OFF_CONTROL && !dat_i[7] |=> ##1 !unit_out_o[0] [*2])
      else $error("disabled unit still drives output");
   chk_route_map: assert property (
      wr && adr_i == CCP_OFF_ROUTE |-> ##2
      pwm_a_timer_o == route($past(dat_i[5:4], 2)) &&
      pwm_b_timer_o == route($past(dat_i[7:6], 2)))
      else $error("standalone timer route wrong");
   chk_clear_flag: assert property (
      wide_timer_clear_o |-> unit_interrupt_flag_o != 2'h0)
      else $error("timer clear without unit event");
   chk_conv_source: assert property (
      converter_trigger_o |-> $past(converter_source_i) != 2'h0)
      else $error("converter trigger without chosen unit");
endmodule
bind ccp_regs ccp_regs_assertions ccp_regs_assertions_i (.clk_i, .rst_i, .cyc_i, .stb_i,
   .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .converter_source_i, .unit_out_o,
   .unit_interrupt_flag_o, .wide_timer_clear_o, .converter_trigger_o, .pwm_a_timer_o,
   .pwm_b_timer_o);

// [bench/ccp_far_model.sv]
/*
 * Far side of ccp_regs: wide timer with hold and clear, one 10-bit
 * period time base with its wrap pulse. Assumes the bench drives hold.
 */
`timescale 1ns/1ps
module ccp_far_model #(
   parameter int LIMIT = 15
) (
   // clock and control
   input  wire logic        clk_i,
   input  wire logic        hold_i,
   input  wire logic        clear_i,
   // timers
   output logic      [15:0] wide_o,
   output logic      [9:0]  base_o,
   output logic             wrap_o
);
   logic [9:0] next_base;
   assign next_base = (base_o == 10'(4 * LIMIT + 3)) ? 10'h0 : base_o + 10'h1;
   initial begin
      wide_o = 16'h0;
      base_o = 10'h0;
      wrap_o = 1'b0;
   end
   // clear request from the unit restarts the wide count
   always @(posedge clk_i) begin
      wide_o <= clear_i ? 16'h0 : wide_o + {15'h0, ~hold_i};
      base_o <= next_base;
      wrap_o <= (next_base == 10'h0);
   end
endmodule

// [bench/ccp_regs_bench.sv]
/*
 * Self-checking bench for ccp_regs: register map, capture sources and
 * edge modes, compare modes, PWM duty. Uses ccp_far_model for timers.
 */
`timescale 1ns/1ps
module ccp_regs_bench;
   import ccp_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, hold, clr, trig, wrap, sec;
   logic [1:0]  conv, out, flag, pa, pb;
   logic [3:0]  lane;
   logic [7:0]  adr_i, src;
   logic [9:0]  base;
   logic [15:0] wide, t;
   logic [31:0] dat_i, dat_o, q;
   int          fail_count, check_count, hi_cnt, clr_cnt, trig_cnt, s_hi, s_clr, s_tr, n, lim;
   logic [3:0]  mtab [4] = '{4'h3, 4'h4, 4'h5, 4'hc};
   logic [1:0]  etab [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
   logic [3:0]  ctab [6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'ha, 4'hb};
   logic        otab [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   logic [23:0] ptab [3] = '{24'h8ffc10, 24'h9f047f, 24'h8f0000};
   int          dtab [3] = '{16, 17, 0};
   ccp_regs ccp_regs_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(lane), .dat_i,
      .dat_o, .ack_o, .wide_timer_i(wide), .period_base_a_i(base), .period_base_b_i(base),
      .period_wrap_a_i(wrap), .period_wrap_b_i(wrap), .remapped_input_pin_i({2{src[0]}}),
      .comparator_one_result_i(src[1]), .comparator_two_result_i(src[2]),
      .pin_change_event_i(src[3]), .logic_cell_result_i(src[7:4]),
      .calendar_seconds_tick_i(sec), .converter_source_i(conv), .unit_out_o(out),
      .unit_interrupt_flag_o(flag), .wide_timer_clear_o(clr), .converter_trigger_o(trig),
      .pwm_a_timer_o(pa), .pwm_b_timer_o(pb));
   ccp_far_model #(.LIMIT(15)) ccp_far_model_i (.clk_i, .hold_i(hold), .clear_i(clr),
      .wide_o(wide), .base_o(base), .wrap_o(wrap));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (out[0] === 1'b1) hi_cnt <= hi_cnt + 1;
      if (clr === 1'b1) clr_cnt <= clr_cnt + 1;
      if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
   end
   // ------------------------------------------------------------
   // bus access and checking
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tmo;
      fail_count++;
      end_of_test();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error: time %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k = 0;
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 16) begin
         k++;
         @(posedge clk_i);
      end
      if (k == 16) tmo();
      q = dat_o;
      {cyc_i, stb_i} <= 2'h0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 8'h0);
      chk(q, e);
   endtask
   task automatic ev(input int k, input logic v, input logic [1:0] e);
      src[k] <= v;
      repeat (4) @(posedge clk_i);
      rd(CCP_OFF_FLAGS, {30'h0, e});
      wr(CCP_OFF_FLAGS, 8'h03);
   endtask
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      {cyc_i, stb_i, we_i, hold, sec, adr_i, src, dat_i} = '0;
      {conv, lane, rst_i} = {2'h1, 4'h1, 1'b1};
      {fail_count, check_count, hi_cnt, clr_cnt, trig_cnt} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(CCP_OFF_CONTROL, 32'h0);
      rd(CCP_OFF_ROUTE, 32'h55);
      wr(CCP_OFF_CONTROL, 8'h7f);
      rd(CCP_OFF_CONTROL, 32'h1f);
      wr(CCP_OFF_CAPSEL, 8'hff);
      rd(CCP_OFF_CAPSEL, 32'h07);
      lane <= 4'h0;
      wr(CCP_OFF_CAPSEL, 8'h02);
      lane <= 4'h1;
      rd(CCP_OFF_CAPSEL, 32'h07);
      wr(8'h30, 8'hff);
      rd(8'h30, 32'h0);
      wr(CCP_OFF_ROUTE, 8'he4);
      rd(CCP_OFF_ROUTE, 32'he4);
      chk({28'h0, pa, pb}, 32'h8);
      wr(CCP_OFF_CAPSEL, 8'h00);
      wr(CCP_OFF_CONTROL, 8'h85);
      ev(0, 1'b1, 2'h0);
      ev(0, 1'b0, 2'h0);
      wr(CCP_OFF_ROUTE, 8'h55);
      $display("register tests done");
      for (int c = 0; c < 8; c++) begin
         hold <= 1'b0;
         wr(CCP_OFF_CAPSEL, 8'(c));
         hold <= 1'b1;
         ev((c + 1) % 8, 1'b1, 2'h0);
         ev(c, 1'b1, 2'h1);
         rd(CCP_OFF_DATA_LOW, {24'h0, wide[7:0]});
         rd(CCP_OFF_DATA_HIGH, {24'h0, wide[15:8]});
         src <= 8'h0;
      end
      wr(CCP_OFF_CAPSEL, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(CCP_OFF_CONTROL, 8'h80 | mtab[i]);
         ev(0, 1'b1, {1'b0, etab[i][0]});
         ev(0, 1'b0, {1'b0, etab[i][1]});
      end
      for (int m = 6; m < 8; m++) begin
         lim = (m == 6) ? 4 : 16;
         // mode 0 restarts the edge prescaler
         wr(CCP_OFF_CONTROL, 8'h00);
         wr(CCP_OFF_CONTROL, 8'h80 | 8'(m));
         for (int j = 1; j <= lim; j++) begin
            ev(0, 1'b1, {1'b0, j == lim});
            ev(0, 1'b0, 2'h0);
         end
      end
      $display("capture tests done");
      hold <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (i == 0 || i > 3) wr(CCP_OFF_CONTROL, 8'h00);
         // one pass routes the converter to the idle unit
         conv <= (i == 2) ? 2'h2 : 2'h1;
         hold <= 1'b1;
         wr(CCP_OFF_CONTROL, 8'h80 | ctab[i]);
         t = wide + 16'd8;
         wr(CCP_OFF_DATA_HIGH, t[15:8]);
         wr(CCP_OFF_DATA_LOW, t[7:0]);
         wr(CCP_OFF_FLAGS, 8'h03);
         {s_hi, s_clr, s_tr} = {hi_cnt, clr_cnt, trig_cnt};
         hold <= 1'b0;
         n = 0;
         while (flag[0] !== 1'b1 && n < 64) begin
            n++;
            @(posedge clk_i);
         end
         if (n == 64) tmo();
         repeat (3) @(posedge clk_i);
         chk({30'h0, flag}, 32'h1);
         chk({30'h0, out}, {31'h0, otab[i]});
         chk(clr_cnt - s_clr, (i == 3 || i == 5));
         chk(trig_cnt - s_tr, (i != 2));
         if (i > 3) chk(hi_cnt - s_hi, 1);
      end
      $display("compare tests done");
      for (int i = 0; i < 3; i++) begin
         wr(CCP_OFF_CONTROL, ptab[i][23:16]);
         wr(CCP_OFF_DATA_HIGH, ptab[i][15:8]);
         wr(CCP_OFF_DATA_LOW, ptab[i][7:0]);
         repeat (160) @(posedge clk_i);
         s_hi = hi_cnt;
         repeat (64) @(posedge clk_i);
         chk(hi_cnt - s_hi, dtab[i]);
      end
      $display("pwm tests done");
      end_of_test();
   end
endmodule
